// ---- common/cfgdec_pkg.sv ----
`default_nettype none
package cfgdec_pkg;
  localparam int unsigned WORD_W = 14;
  localparam logic [15:0] CFG_WORD_ONE_ADDR = 16'h8007;
  localparam logic [15:0] CFG_WORD_TWO_ADDR = 16'h8008;
  localparam logic [13:0] CFG_BLANK = 14'h3FFF;
  // Unimplemented bits forced to one
  localparam logic [13:0] W1_UNIMPL_MASK = 14'h0100;
  localparam logic [13:0] W2_UNIMPL_MASK = 14'h00EC;
  // Word one field positions
  localparam int unsigned W1_MON = 13;
  localparam int unsigned W1_SWO = 12;
  localparam int unsigned W1_CLKO = 11;
  localparam int unsigned W1_BOR_LO = 9;
  localparam int unsigned W1_CP = 7;
  localparam int unsigned W1_RSTPIN = 6;
  localparam int unsigned W1_PWRT = 5;
  localparam int unsigned W1_WDT_LO = 3;
  localparam int unsigned W1_OSC_LO = 0;
  // Word two field positions
  localparam int unsigned W2_LVP = 13;
  localparam int unsigned W2_DBG = 12;
  localparam int unsigned W2_LOW_POWER_BROWNOUT_EN_N = 11;
  localparam int unsigned W2_BROWNOUT_TRIP_SELECT = 10;
  localparam int unsigned W2_STK = 9;
  localparam int unsigned W2_VCAP = 4;
  localparam int unsigned W2_WRT_LO = 0;
  // Protected region top addresses
  localparam logic [13:0] WP_TOP_SMALL = 14'h01FF;
  localparam logic [13:0] WP_TOP_8K_MID = 14'h0FFF;
  localparam logic [13:0] WP_TOP_16K_MID = 14'h1FFF;
  localparam logic [13:0] WP_TOP_8K_ALL = 14'h1FFF;
  localparam logic [13:0] WP_TOP_16K_ALL = 14'h3FFF;

  typedef enum logic [1:0] {
    CFGDEC_MODE_OFF = 2'h0,
    CFGDEC_MODE_SOFT = 2'h1,
    CFGDEC_MODE_RUN = 2'h2,
    CFGDEC_MODE_ON = 2'h3
  } cfgdec_mode_t;

  typedef enum logic [2:0] {
    CFGDEC_OSC_LP = 3'h0,
    CFGDEC_OSC_XT = 3'h1,
    CFGDEC_OSC_HS = 3'h2,
    CFGDEC_OSC_RC = 3'h3,
    CFGDEC_OSC_INT = 3'h4,
    CFGDEC_OSC_ECL = 3'h5,
    CFGDEC_OSC_ECM = 3'h6,
    CFGDEC_OSC_ECH = 3'h7
  } cfgdec_osc_t;

  // Decoded settings handed to the clock, reset and memory logic
  typedef struct packed {
    logic clock_monitor_en;
    logic clock_switchover_en;
    logic clock_output_drive;
    logic osc_pin_crystal;
    cfgdec_mode_t brownout_mode;
    logic code_protect;
    logic reset_pin_is_reset;
    logic reset_pin_pullup_forced;
    logic powerup_timer_en;
    cfgdec_mode_t watchdog_mode;
    cfgdec_osc_t oscillator_select;
    logic low_voltage_program_en;
    logic debugger_pins;
    logic low_power_brownout_en;
    logic brownout_trip_low;
    logic stack_fault_reset_en;
    logic regulator_cap_pin_en;
    logic write_protect_any;
    logic [13:0] write_protect_top;
  } cfgdec_set_t;

  typedef struct packed {
    logic [13:0] word_one;
    logic [13:0] word_two;
    logic loaded;
    logic stack_overflow_flag;
    logic stack_underflow_flag;
    logic stack_reset;
    logic [13:0] rdata;
    logic [7:0] ext_rdata;
    cfgdec_set_t set;
  } cfgdec_state_t;
endpackage
`default_nettype wire

// ---- design/cfgdec_top.sv ----
`default_nettype none
// Behaviour
// [R1] With stack-fault reset on, overflow/underflow resets and sets its flag
// [R2] Word one answers at 0x8007, word two at 0x8008
// [R3] Blank words read all ones; unimplemented bits always read one
// [R4] Word one bit 13 enables the fail-safe clock monitor
// [R5] Word one bit 12 enables internal/external switchover
// [R6] Bit 11 ignored in crystal modes; zero drives clock out
// [R7] Brown-out field: 11 on, 10 run only, 01 software, 00 off
// [R8] Word one bit 7 low enables code protection
// [R9] Bit 6 ignored under LOW_VOLTAGE_PROGRAM_EN; one is reset with pull-up, zero input
// [R10] Word one bit 5 low enables power-up timer
// [R11] Watchdog field: 11 on, 10 run only, 01 software, 00 off
// [R12] Oscillator field selects EC high/med/low, internal, RC, HS/XT/LP
// [R13] Word two bit 13 enables low-voltage programming
// [R14] Word two bit 12 low dedicates programming pins to debugger
// [R15] Word two bit 11 low enables low-power brown-out detector
// [R16] Word two bit 10 one selects low trip, zero high trip
// [R17] Stack fault resets only when word two bit 9 is one
// [R18] Regulator parts: bit 4 low enables capacitor pin; else ignored
// [R19] 8K parts: write protect none, 1FFh, FFFh, whole range
// [R20] 16K parts: write protect none, 1FFh, 1FFFh, 3FFFh
// [R21] Code protect blocks external access, reads zero; core reads unaffected
// [R22] Words latch on the first edge after reset and hold until the next reset
module cfgdec_top #(
  parameter bit HAS_REGULATOR = 1'b1,
  parameter bit FLASH_16K = 1'b0
) (
  input wire logic I_CLK, // System clock
  input wire logic I_RST, // Synchronous reset, active high
  input wire logic [13:0] I_NVM_WORD_ONE, // Stored word one
  input wire logic [13:0] I_NVM_WORD_TWO, // Stored word two
  input wire logic I_NVM_BLANK, // Configuration memory erased
  input wire logic [15:0] I_ADDR, // Register address
  input wire logic [13:0] I_WDATA, // Write data, ignored
  input wire logic I_WR, // Write strobe
  input wire logic I_RD, // Read strobe
  output logic [13:0] O_RDATA, // Read data, cycle after strobe
  input wire logic I_STACK_PUSH_OVF, // Push beyond level sixteen
  input wire logic I_STACK_POP_UNF, // Pop below level one
  input wire logic I_FLAG_CLR_OVF, // Software clears overflow flag
  input wire logic I_FLAG_CLR_UNF, // Software clears underflow flag
  input wire logic I_EXT_RD, // External program memory read
  input wire logic [7:0] I_EXT_MEM_DATA, // Memory data for that read
  output logic [7:0] O_EXT_RDATA, // External read result
  output logic O_EXT_ACCESS_OK, // External reads/writes allowed
  output logic O_STACK_RESET, // One-cycle reset request
  output logic O_STACK_OVERFLOW_FLAG, // Sticky overflow flag
  output logic O_STACK_UNDERFLOW_FLAG, // Sticky underflow flag
  output logic O_LOADED, // Words latched since reset
  output cfgdec_pkg::cfgdec_set_t O_SET // Decoded settings
);

  cfgdec_pkg::cfgdec_state_t s_q;
  cfgdec_pkg::cfgdec_state_t s_d;
  logic [13:0] w1;
  logic [13:0] w2;
  logic [1:0] wrt;
  logic stack_fault_reset_en;

  // Source words: erased memory reads as ones, unimplemented bits forced
  always_comb begin
    w1 = (I_NVM_BLANK ? cfgdec_pkg::CFG_BLANK : I_NVM_WORD_ONE)
      | cfgdec_pkg::W1_UNIMPL_MASK; // [R3]
    w2 = (I_NVM_BLANK ? cfgdec_pkg::CFG_BLANK : I_NVM_WORD_TWO)
      | cfgdec_pkg::W2_UNIMPL_MASK; // [R3]
  end

  assign wrt = s_q.word_two[cfgdec_pkg::W2_WRT_LO +: 2];
  assign stack_fault_reset_en = s_q.set.stack_fault_reset_en;

  // Next state: latch once after reset and decode from the held words; then only flags, the stack reset, read data and external read data move
  always_comb begin
    s_d = s_q;
    s_d.stack_reset = 1'b0;
    s_d.rdata = 14'h0000;
    if (!s_q.loaded) begin
      // Capture is clocked after release so no port feeds the reset value
      s_d.word_one = w1; // [R22]
      s_d.word_two = w2; // [R22]
      s_d.loaded = 1'b1;
    end
    // Decode from the held words; writes never reach them
    s_d.set.clock_monitor_en = s_q.word_one[cfgdec_pkg::W1_MON]; // [R4]
    s_d.set.clock_switchover_en = s_q.word_one[cfgdec_pkg::W1_SWO]; // [R5]
    s_d.set.oscillator_select =
      cfgdec_pkg::cfgdec_osc_t'(s_q.word_one[cfgdec_pkg::W1_OSC_LO +: 3]); // [R12]
    s_d.set.osc_pin_crystal =
      (s_q.word_one[cfgdec_pkg::W1_OSC_LO +: 3] <= 3'h2); // [R6]
    s_d.set.clock_output_drive = !s_d.set.osc_pin_crystal
      && !s_q.word_one[cfgdec_pkg::W1_CLKO]; // [R6]
    s_d.set.brownout_mode =
      cfgdec_pkg::cfgdec_mode_t'(s_q.word_one[cfgdec_pkg::W1_BOR_LO +: 2]); // [R7]
    s_d.set.code_protect = !s_q.word_one[cfgdec_pkg::W1_CP]; // [R8]
    s_d.set.low_voltage_program_en = s_q.word_two[cfgdec_pkg::W2_LVP]; // [R13]
    // Under LOW_VOLTAGE_PROGRAM_EN the pin is always reset with pull-up
    s_d.set.reset_pin_is_reset = s_q.word_two[cfgdec_pkg::W2_LVP]
      || s_q.word_one[cfgdec_pkg::W1_RSTPIN]; // [R9]
    s_d.set.reset_pin_pullup_forced = s_d.set.reset_pin_is_reset; // [R9]
    s_d.set.powerup_timer_en = !s_q.word_one[cfgdec_pkg::W1_PWRT]; // [R10]
    s_d.set.watchdog_mode =
      cfgdec_pkg::cfgdec_mode_t'(s_q.word_one[cfgdec_pkg::W1_WDT_LO +: 2]); // [R11]
    s_d.set.debugger_pins = !s_q.word_two[cfgdec_pkg::W2_DBG]; // [R14]
    s_d.set.low_power_brownout_en = !s_q.word_two[cfgdec_pkg::W2_LOW_POWER_BROWNOUT_EN_N]; // [R15]
    s_d.set.brownout_trip_low = s_q.word_two[cfgdec_pkg::W2_BROWNOUT_TRIP_SELECT]; // [R16]
    s_d.set.stack_fault_reset_en = s_q.word_two[cfgdec_pkg::W2_STK]; // [R17]
    s_d.set.regulator_cap_pin_en = HAS_REGULATOR
      && !s_q.word_two[cfgdec_pkg::W2_VCAP]; // [R18]
    // Write-protect region top, by flash size
    s_d.set.write_protect_any = (wrt != 2'h3); // [R19] [R20]
    case (wrt)
      2'h3: s_d.set.write_protect_top = 14'h0000;
      2'h2: s_d.set.write_protect_top = cfgdec_pkg::WP_TOP_SMALL; // [R19] [R20]
      2'h1: s_d.set.write_protect_top = FLASH_16K ? cfgdec_pkg::WP_TOP_16K_MID
        : cfgdec_pkg::WP_TOP_8K_MID; // [R19] [R20]
      default: s_d.set.write_protect_top = FLASH_16K ? cfgdec_pkg::WP_TOP_16K_ALL
        : cfgdec_pkg::WP_TOP_8K_ALL; // [R19] [R20]
    endcase
    // Stack faults: flags set once loaded whatever the enable, set wins over clear
    if (I_FLAG_CLR_OVF) begin
      s_d.stack_overflow_flag = 1'b0;
    end
    if (I_FLAG_CLR_UNF) begin
      s_d.stack_underflow_flag = 1'b0;
    end
    if (s_q.loaded && I_STACK_PUSH_OVF) begin
      s_d.stack_overflow_flag = 1'b1; // [R1]
    end
    if (s_q.loaded && I_STACK_POP_UNF) begin
      s_d.stack_underflow_flag = 1'b1; // [R1]
    end
    s_d.stack_reset = s_q.loaded && stack_fault_reset_en
      && (I_STACK_PUSH_OVF || I_STACK_POP_UNF); // [R1] [R17]
    // Register reads; unmapped addresses return zero
    if (I_RD) begin
      if (I_ADDR == cfgdec_pkg::CFG_WORD_ONE_ADDR) begin
        s_d.rdata = s_q.word_one; // [R2]
      end else if (I_ADDR == cfgdec_pkg::CFG_WORD_TWO_ADDR) begin
        s_d.rdata = s_q.word_two; // [R2]
      end
    end
    // External program reads return zero while protected
    s_d.ext_rdata = (I_EXT_RD && !s_d.set.code_protect) ? I_EXT_MEM_DATA
      : 8'h00; // [R21]
  end

  // State register; reset leaves words blank until the capture cycle
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      s_q <= '0;
      s_q.word_one <= cfgdec_pkg::CFG_BLANK;
      s_q.word_two <= cfgdec_pkg::CFG_BLANK;
      s_q.set.reset_pin_is_reset <= 1'b1;
      s_q.set.reset_pin_pullup_forced <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_RDATA = s_q.rdata;
  assign O_EXT_RDATA = s_q.ext_rdata;
  assign O_EXT_ACCESS_OK = !s_q.set.code_protect; // [R21]
  assign O_STACK_RESET = s_q.stack_reset;
  assign O_STACK_OVERFLOW_FLAG = s_q.stack_overflow_flag;
  assign O_STACK_UNDERFLOW_FLAG = s_q.stack_underflow_flag;
  assign O_LOADED = s_q.loaded;
  assign O_SET = s_q.set;

  // Settings never change after the edge that follows the load
  hold_stable_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R22]
    $past(s_q.loaded, 2) |-> $stable(O_SET))
    else $error("settings changed after load");
  stack_reset_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R17]
    (s_q.loaded && I_STACK_PUSH_OVF) |=> (O_STACK_RESET == stack_fault_reset_en))
    else $error("stack reset does not follow enable");
  ovf_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R1]
    (s_q.loaded && I_STACK_PUSH_OVF) |=> O_STACK_OVERFLOW_FLAG)
    else $error("overflow flag not set");
  unf_flag_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R1]
    (s_q.loaded && I_STACK_POP_UNF) |=> O_STACK_UNDERFLOW_FLAG)
    else $error("underflow flag not set");
  read_one_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R2]
    (I_RD && I_ADDR == cfgdec_pkg::CFG_WORD_ONE_ADDR) |=> (O_RDATA == s_q.word_one))
    else $error("word one read wrong");
  unimpl_one_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R3]
    (s_q.word_one[8] && (&s_q.word_two[7:5]) && (&s_q.word_two[3:2])))
    else $error("unimplemented bit reads zero");
  ext_block_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R21]
    (s_q.loaded && O_SET.code_protect && $stable(O_SET)) |=> (O_EXT_RDATA == 8'h00))
    else $error("protected read not zero");
  clk_out_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R6]
    O_SET.osc_pin_crystal |-> !O_SET.clock_output_drive)
    else $error("clock out driven in crystal mode");
  code_prot_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R8]
    $past(s_q.loaded, 2) |-> (O_SET.code_protect == !s_q.word_one[7]))
    else $error("code protect polarity wrong");

  // Settled: words held over two edges, so the decode from them now stands
  sequence settled_s;
    s_q.loaded && $past(s_q.loaded);
  endsequence

  // Stack events the decoder acts on; ignored before the words are held
  sequence ovf_ev_s;
    s_q.loaded && I_STACK_PUSH_OVF;
  endsequence

  sequence unf_ev_s;
    s_q.loaded && I_STACK_POP_UNF;
  endsequence

  // Clock monitor follows its bit directly
  mon_decode_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R4]
    settled_s |-> (O_SET.clock_monitor_en == s_q.word_one[cfgdec_pkg::W1_MON]))
    else $error("clock monitor decode wrong");

  // Switchover follows its bit directly
  swo_decode_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R5]
    settled_s |-> (O_SET.clock_switchover_en == s_q.word_one[cfgdec_pkg::W1_SWO]))
    else $error("switchover decode wrong");

  // Oscillator code is passed on unchanged
  osc_decode_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R12]
    settled_s |-> (O_SET.oscillator_select == s_q.word_one[2:0]))
    else $error("oscillator decode wrong");

  // Crystal modes are exactly codes 0 to 2
  xtal_pin_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R6]
    settled_s |-> (O_SET.osc_pin_crystal
      == (!s_q.word_one[2] && (s_q.word_one[1:0] != 2'h3))))
    else $error("crystal pin decode wrong");

  // Outside crystal modes a zero drives the clock out
  clk_drive_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R6]
    settled_s ##0 !O_SET.osc_pin_crystal
      |-> (O_SET.clock_output_drive == !s_q.word_one[cfgdec_pkg::W1_CLKO]))
    else $error("clock out decode wrong");

  // Brown-out mode code passed on unchanged
  bor_mode_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R7]
    settled_s |-> (O_SET.brownout_mode == s_q.word_one[cfgdec_pkg::W1_BOR_LO +: 2]))
    else $error("brown-out mode wrong");

  // Low-voltage programming overrides the reset pin select
  rst_pin_lvp_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R9]
    settled_s ##0 s_q.word_two[cfgdec_pkg::W2_LVP] |-> O_SET.reset_pin_is_reset)
    else $error("reset pin not reset under lvp");

  // Without it the select bit decides
  rst_pin_hv_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R9]
    settled_s ##0 !s_q.word_two[cfgdec_pkg::W2_LVP]
      |-> (O_SET.reset_pin_is_reset == s_q.word_one[cfgdec_pkg::W1_RSTPIN]))
    else $error("reset pin select wrong");

  // Pull-up is forced whenever the pin is a reset input
  pullup_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R9]
    O_SET.reset_pin_pullup_forced == O_SET.reset_pin_is_reset)
    else $error("reset pin pull-up wrong");

  // Power-up timer bit is active low
  pwrt_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R10]
    settled_s |-> (O_SET.powerup_timer_en == !s_q.word_one[cfgdec_pkg::W1_PWRT]))
    else $error("power-up timer decode wrong");

  // Watchdog mode code passed on unchanged
  wdt_mode_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R11]
    settled_s |-> (O_SET.watchdog_mode == s_q.word_one[cfgdec_pkg::W1_WDT_LO +: 2]))
    else $error("watchdog mode wrong");

  // Word two single-bit settings
  lvp_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R13]
    settled_s |-> (O_SET.low_voltage_program_en == s_q.word_two[cfgdec_pkg::W2_LVP]))
    else $error("lvp decode wrong");

  dbg_pins_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R14]
    settled_s |-> (O_SET.debugger_pins == !s_q.word_two[cfgdec_pkg::W2_DBG]))
    else $error("debugger pin decode wrong");

  low_power_brownout_en_n_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R15]
    settled_s |-> (O_SET.low_power_brownout_en == !s_q.word_two[cfgdec_pkg::W2_LOW_POWER_BROWNOUT_EN_N]))
    else $error("low-power brown-out decode wrong");

  bor_trip_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R16]
    settled_s |-> (O_SET.brownout_trip_low == s_q.word_two[cfgdec_pkg::W2_BROWNOUT_TRIP_SELECT]))
    else $error("brown-out trip decode wrong");

  stk_en_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R17]
    settled_s |-> (O_SET.stack_fault_reset_en == s_q.word_two[cfgdec_pkg::W2_STK]))
    else $error("stack reset enable decode wrong");

  // Parts without a regulator never enable the capacitor pin
  vcap_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R18]
    settled_s |-> (O_SET.regulator_cap_pin_en
      == (HAS_REGULATOR && !s_q.word_two[cfgdec_pkg::W2_VCAP])))
    else $error("capacitor pin decode wrong");

  // Write protection: any region unless the field is all ones
  wp_any_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R19] [R20]
    settled_s |-> (O_SET.write_protect_any == (wrt != 2'h3)))
    else $error("write protect enable wrong");

  wp_none_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R19] [R20]
    settled_s ##0 (wrt == 2'h3) |-> (O_SET.write_protect_top == 14'h0000))
    else $error("unprotected top not zero");

  wp_small_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R19] [R20]
    settled_s ##0 (wrt == 2'h2) |-> (O_SET.write_protect_top == cfgdec_pkg::WP_TOP_SMALL))
    else $error("small region top wrong");

  // Middle and whole regions depend on flash size
  wp_mid_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R19] [R20]
    settled_s ##0 (wrt == 2'h1) |-> (O_SET.write_protect_top
      == (FLASH_16K ? cfgdec_pkg::WP_TOP_16K_MID : cfgdec_pkg::WP_TOP_8K_MID)))
    else $error("middle region top wrong");

  wp_all_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R19] [R20]
    settled_s ##0 (wrt == 2'h0) |-> (O_SET.write_protect_top
      == (FLASH_16K ? cfgdec_pkg::WP_TOP_16K_ALL : cfgdec_pkg::WP_TOP_8K_ALL)))
    else $error("whole region top wrong");

  // Register reads: data for one cycle only, zero elsewhere
  read_two_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R2]
    (s_q.loaded && I_RD && I_ADDR == cfgdec_pkg::CFG_WORD_TWO_ADDR)
      |=> (O_RDATA == s_q.word_two))
    else $error("word two read wrong");

  read_gap_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R2]
    !I_RD |=> (O_RDATA == 14'h0000))
    else $error("read data outside read cycle");

  read_unmap_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R2]
    (I_RD && I_ADDR != cfgdec_pkg::CFG_WORD_ONE_ADDR
      && I_ADDR != cfgdec_pkg::CFG_WORD_TWO_ADDR) |=> (O_RDATA == 14'h0000))
    else $error("unmapped read not zero");

  // Unprotected external reads pass the memory data through
  ext_pass_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R21]
    settled_s ##0 (I_EXT_RD && !O_SET.code_protect)
      |=> (O_EXT_RDATA == $past(I_EXT_MEM_DATA)))
    else $error("unprotected read data wrong");

  // Flags clear on request when no event competes
  ovf_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R1]
    (I_FLAG_CLR_OVF && !I_STACK_PUSH_OVF) |=> !O_STACK_OVERFLOW_FLAG)
    else $error("overflow flag not cleared");

  unf_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R1]
    (I_FLAG_CLR_UNF && !I_STACK_POP_UNF) |=> !O_STACK_UNDERFLOW_FLAG)
    else $error("underflow flag not cleared");

  // Underflow resets too when enabled
  unf_reset_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R17]
    unf_ev_s |=> (O_STACK_RESET == stack_fault_reset_en))
    else $error("underflow reset does not follow enable");

  // A reset request only ever follows a stack event
  stk_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R17]
    !(s_q.loaded && (I_STACK_PUSH_OVF || I_STACK_POP_UNF)) |=> !O_STACK_RESET)
    else $error("spurious stack reset");

  // Overflow with enable off sets the flag but never resets
  ovf_no_rst_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R17]
    ovf_ev_s ##0 !stack_fault_reset_en |=> !O_STACK_RESET)
    else $error("stack reset while disabled");

  // Erased memory reads as all ones once captured
  blank_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R3]
    (!s_q.loaded && I_NVM_BLANK) |=> (s_q.word_one == cfgdec_pkg::CFG_BLANK
      && s_q.word_two == cfgdec_pkg::CFG_BLANK))
    else $error("blank words not all ones");

  // Capture happens on the first edge after release
  capture_a: assert property (@(posedge I_CLK) // [R22]
    $fell(I_RST) |-> !s_q.loaded ##1 s_q.loaded)
    else $error("words not captured after reset");

  // Held words never move until the next reset
  word_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST) // [R22]
    s_q.loaded |=> ($stable(s_q.word_one) && $stable(s_q.word_two)))
    else $error("held words changed");

endmodule
`default_nettype wire

// ---- dv/cfgdec_stack_model.sv ----
`default_nettype none
module cfgdec_stack_model (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_call, // Push request
  input wire logic i_ret, // Pop request
  output logic o_push_ovf, // Push beyond level sixteen
  output logic o_pop_unf // Pop below level one
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] depth_q;
  // Faults are flagged in the same cycle as the offending push or pop
  assign o_push_ovf = i_call && depth_q == 5'h10;
  assign o_pop_unf = i_ret && !i_call && depth_q == 5'h00;
  // Sixteen levels; a faulty access leaves the depth as it was
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      depth_q <= 5'h00;
    end else if (i_call && depth_q != 5'h10) begin
      depth_q <= depth_q + 5'h01;
    end else if (i_ret && !i_call && depth_q != 5'h00) begin
      depth_q <= depth_q - 5'h01;
    end
  end
endmodule
`default_nettype wire

// ---- dv/test_config_word_decoder.sv ----
`default_nettype none
module test_config_word_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, blank = 0, rd = 0, wr = 0, ext = 0, call = 0, ret = 0;
  logic cov = 0, cun = 0, rd_p = 0, po, pu, eok, srst, fo, fu, ld;
  logic [13:0] w1 = 0, w2 = 0, wd = 0, rdata, e1, e2;
  logic [15:0] addr = 0;
  logic [7:0] md = 0, erd;
  logic [2:0] osc;
  logic [1:0] wp;
  logic [13:0] q[$];
  int seed = 50171, fails = 0, n_checks = 0, i;
  cfgdec_pkg::cfgdec_set_t st;
  cfgdec_top cfgdec_top_inst (.I_CLK(clk), .I_RST(rst), .I_NVM_WORD_ONE(w1),
    .I_NVM_WORD_TWO(w2), .I_NVM_BLANK(blank), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_STACK_PUSH_OVF(po), .I_STACK_POP_UNF(pu),
    .I_FLAG_CLR_OVF(cov), .I_FLAG_CLR_UNF(cun), .I_EXT_RD(ext), .I_EXT_MEM_DATA(md),
    .O_EXT_RDATA(erd), .O_EXT_ACCESS_OK(eok), .O_STACK_RESET(srst),
    .O_STACK_OVERFLOW_FLAG(fo), .O_STACK_UNDERFLOW_FLAG(fu), .O_LOADED(ld), .O_SET(st));
  cfgdec_stack_model cfgdec_stack_model_inst (.i_clk(clk), .i_rst(rst), .i_call(call),
    .i_ret(ret), .o_push_ovf(po), .o_pop_unf(pu));
  initial forever #4 clk = ~clk;
  task cmp(string n, logic [13:0] e, logic [13:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task rd_reg(logic [15:0] a, logic [13:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    q.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  task pulse_n(int n, bit up);
    repeat (n) @(posedge clk) if (up) call <= 1; else ret <= 1;
    @(posedge clk);
    call <= 0;
    ret <= 0;
    @(negedge clk);
  endtask
  // Read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge clk) rd_p <= rd;
  always @(negedge clk) if (rd_p) cmp("rdata", q.pop_front(), rdata);
  // Whole run is well under a thousand cycles a pass
  initial begin
    #400000;
    fails++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    for (i = 0; i < 12; i++) begin
      rst <= 1;
      w1 <= 14'($random(seed));
      w2 <= 14'($random(seed));
      blank <= (i == 0);
      repeat (2) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      e1 = blank ? 14'h3FFF : w1 | cfgdec_pkg::W1_UNIMPL_MASK;
      e2 = blank ? 14'h3FFF : w2 | cfgdec_pkg::W2_UNIMPL_MASK;
      osc = e1[2:0];
      wp = e2[1:0];
      cmp("loaded", 1, ld);
      cmp("monitor", e1[13], st.clock_monitor_en);
      cmp("switchover", e1[12], st.clock_switchover_en);
      cmp("clock_output_pin", osc > 3'h2 && !e1[11], st.clock_output_drive);
      cmp("brownout", e1[10:9], st.brownout_mode);
      cmp("protect", !e1[7], st.code_protect);
      cmp("resetpin", e2[13] || e1[6], st.reset_pin_is_reset);
      cmp("pullup", e2[13] || e1[6], st.reset_pin_pullup_forced);
      cmp("xtal", osc <= 3'h2, st.osc_pin_crystal);
      cmp("pwrt", !e1[5], st.powerup_timer_en);
      cmp("watchdog", e1[4:3], st.watchdog_mode);
      cmp("osc", osc, st.oscillator_select);
      cmp("lvp", e2[13], st.low_voltage_program_en);
      cmp("debug", !e2[12], st.debugger_pins);
      cmp("low_power_brownout_en_n", !e2[11], st.low_power_brownout_en);
      cmp("trip", e2[10], st.brownout_trip_low);
      cmp("stkrst", e2[9], st.stack_fault_reset_en);
      cmp("vcap", !e2[4], st.regulator_cap_pin_en);
      cmp("wrtany", wp != 2'h3, st.write_protect_any);
      cmp("wrttop", wp == 2'h3 ? 14'h0 : wp == 2'h2 ? 14'h01FF : wp == 2'h1 ? 14'h0FFF
        : 14'h1FFF, st.write_protect_top);
      @(posedge clk);
      wr <= 1;
      addr <= 16'h8007;
      wd <= 14'($random(seed));
      @(posedge clk);
      wr <= 0;
      rd_reg(16'h8007, e1);
      rd_reg(16'h8008, e2);
      rd_reg(16'h8006, 14'h0000);
      @(posedge clk);
      ext <= 1;
      md <= 8'($random(seed));
      @(posedge clk);
      ext <= 0;
      @(negedge clk);
      cmp("extdata", e1[7] ? md : 8'h00, erd);
      cmp("extok", e1[7], eok);
      pulse_n(17, 1);
      cmp("ovf", 1, fo);
      cmp("ovfrst", e2[9], srst);
      pulse_n(17, 0);
      cmp("unf", 1, fu);
      cmp("unfrst", e2[9], srst);
      @(posedge clk);
      cov <= 1;
      cun <= 1;
      @(posedge clk);
      cov <= 0;
      cun <= 0;
      @(negedge clk);
      cmp("clr", 0, {fo, fu});
      $display("test %0d done", i);
    end
    final_report;
  end
endmodule
`default_nettype wire
